// ===== ifcs_cfg.svh
// register offsets, field positions, reset value, queue depth and summary bit positions of the status bank
`ifndef IFCS_CFG_SVH
`define IFCS_CFG_SVH
`define IFCS_OFS_TIMER 6'h18
`define IFCS_OFS_ERROR 6'h19
`define IFCS_OFS_FILL 6'h1a
`define IFCS_OFS_COND 6'h1b
`define IFCS_OFS_COLL 6'h1c
`define IFCS_OFS_MAIN 6'h17
`define IFCS_RST_VAL 8'h00
`define IFCS_FIFO_DEPTH 7'h60
`define IFCS_COND_UNF 6
`define IFCS_COND_OVR 5
`define IFCS_COND_NCP 4
`define IFCS_COND_NP 0
`define IFCS_SUM_TIM 1
`define IFCS_SUM_ERR 0
`endif

// ===== ifcs_pkg.sv
// types shared by the status bank
package ifcs_pkg;
  // one-cycle event pulses feeding the timer/field register
  typedef struct packed {
    logic cmd_done;
    logic no_resp_expire;
    logic gp_expire;
    logic field_on;
    logic field_off;
    logic ca_collision;
    logic ca_guard_done;
    logic target_rate;
  } ifcs_tim_ev_t;
  // one-cycle event pulses feeding the error/wake-up register
  typedef struct packed {
    logic crc_err;
    logic parity_err;
    logic soft_frame_error_flag;
    logic hard_frame_error_flag;
    logic wake_timer_flag;
    logic wake_amp;
    logic wake_phase;
    logic wake_cap;
  } ifcs_err_ev_t;
  // end-of-receive report about the last queue byte
  typedef struct packed {
    logic valid;
    logic incomplete;
    logic [2:0] last_byte_valid_bits;
    logic last_byte_parity_missing;
  } ifcs_last_t;
  // collision report from the framing logic
  typedef struct packed {
    logic valid;
    logic long_msg;
    logic [3:0] bytes;
    logic [2:0] bits;
    logic collision_on_parity;
  } ifcs_coll_t;
  // register read decode states
  typedef enum logic [1:0] {
    IFCS_IDLE = 2'b01,
    IFCS_HOLD = 2'b10
  } ifcs_rd_state_t;
endpackage

// ===== ifcs_flag8.sv
// eight sticky flags, set wins over clear, with synchronous clear
module ifcs_flag8 (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic [7:0] set,
  input wire logic clr,
  // state
  output logic [7:0] flags
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  // a flag set in the clearing cycle survives so no event is lost
  assign flags_nxt = (clr ? 8'h00 : flags_r) | set;
  assign flags = flags_r;
  // flag store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule

// ===== ifcs_bank.sv
// timer/field, error/wake-up, queue status and collision status registers
`include "ifcs_cfg.svh"
module ifcs_bank
  import ifcs_pkg::*;
#(
  parameter int DEPTH = 96
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // set-default command pulse
  input wire logic set_default,
  // register read port from the host serial engine
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // main interrupt read strobe from the main register block
  input wire logic main_rd,
  // event sources
  input ifcs_tim_ev_t tim_ev,
  input ifcs_err_ev_t err_ev,
  input wire logic wake_irq_every,
  // queue state from the storage
  input wire logic [6:0] fifo_count,
  input wire logic fifo_underflow,
  input wire logic fifo_overflow,
  input ifcs_last_t last_info,
  // collision report
  input ifcs_coll_t coll_in,
  // summaries to main interrupt register
  output logic [1:0] main_summary
);
  // read strobes per register
  wire rd_tim = rd_en && (rd_addr == `IFCS_OFS_TIMER);
  wire rd_err = rd_en && (rd_addr == `IFCS_OFS_ERROR);
  wire rd_fill = rd_en && (rd_addr == `IFCS_OFS_FILL);
  wire rd_cond = rd_en && (rd_addr == `IFCS_OFS_COND);
  wire rd_coll = rd_en && (rd_addr == `IFCS_OFS_COLL);
  // either main-read or set-default empties the event registers
  wire ev_clr = main_rd || set_default;
  // gather timer/field events in bit order 7..0
  wire [7:0] tim_set = tim_ev;
  // wake timer only flags when every-timeout option chosen
  wire [7:0] err_set = {err_ev[7:5], err_ev[4],
                        err_ev.wake_timer_flag & wake_irq_every,
                        err_ev[2:0]};
  logic [7:0] tim_flags;
  logic [7:0] err_flags;
  // timer/field flag store
  ifcs_flag8 u_tim (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(tim_set),
    .clr(ev_clr),
    .flags(tim_flags)
  );
  // error/wake-up flag store
  ifcs_flag8 u_err (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(err_set),
    .clr(ev_clr),
    .flags(err_flags)
  );
  // summary pending: set on event, cleared by reading its detail register
  logic [1:0] sum_r;
  wire [1:0] sum_set = {|tim_set, |err_set};
  wire [1:0] sum_clr = {rd_tim, rd_err};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_r <= 2'b00;
    end else if (set_default) begin
      // an event landing with set-default survives, as in the flag stores
      sum_r <= sum_set;
    end else begin
      sum_r <= (sum_r & ~sum_clr) | sum_set;
    end
  end
  assign main_summary = sum_r;
  // last-byte info, cleared on read or set-default, bits 4..1 shown as zero while queue empty; report wins over clear
  logic ncp_r;
  logic [2:0] lb_r;
  logic np_r;
  logic unf_r;
  logic ovr_r;
  wire fifo_empty = (fifo_count == 7'h00);
  wire lb_clr = rd_cond || set_default;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ncp_r <= 1'b0;
      lb_r <= 3'h0;
      np_r <= 1'b0;
    end else if (last_info.valid) begin
      ncp_r <= last_info.incomplete;
      lb_r <= last_info.incomplete ? last_info.last_byte_valid_bits : 3'h0;
      np_r <= last_info.last_byte_parity_missing;
    end else if (lb_clr) begin
      ncp_r <= 1'b0;
      lb_r <= 3'h0;
      np_r <= 1'b0;
    end
  end
  // underflow and overflow are sticky until set-default
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unf_r <= 1'b0;
      ovr_r <= 1'b0;
    end else if (set_default) begin
      unf_r <= fifo_underflow;
      ovr_r <= fifo_overflow;
    end else begin
      unf_r <= unf_r | fifo_underflow;
      ovr_r <= ovr_r | fifo_overflow;
    end
  end
  // collision record: long messages ignored, parity flag first collision only
  logic [7:0] coll_r;
  logic first_seen_r;
  wire coll_take = coll_in.valid && !coll_in.long_msg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_r <= `IFCS_RST_VAL;
      first_seen_r <= 1'b0;
    end else if (set_default) begin
      coll_r <= `IFCS_RST_VAL;
      first_seen_r <= 1'b0;
    end else if (coll_take) begin
      coll_r[7:1] <= {coll_in.bytes, coll_in.bits};
      coll_r[0] <= coll_in.collision_on_parity && !first_seen_r;
      first_seen_r <= 1'b1;
    end
  end
  // count clipped to depth, zero when empty; top bit always zero
  wire [6:0] cnt = fifo_empty ? 7'h00 :
    ((fifo_count > 7'(DEPTH)) ? 7'(DEPTH) : fifo_count);
  wire [7:0] fill_val = {1'b0, cnt};
  wire [7:0] cond_val = {1'b0, unf_r, ovr_r, ncp_r & !fifo_empty,
                         fifo_empty ? 3'h0 : lb_r, np_r};
  wire [7:0] rd_mux = rd_tim ? tim_flags :
                      rd_err ? err_flags :
                      rd_fill ? fill_val :
                      rd_cond ? cond_val :
                      rd_coll ? coll_r : 8'h00;
  // registered read data, hit flag combinational
  logic [7:0] rd_data_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (rd_en) begin
      rd_data_r <= rd_mux;
    end
  end
  assign rd_data = rd_data_r;
  assign rd_hit = rd_tim | rd_err | rd_fill | rd_cond | rd_coll;
endmodule

// ===== ifcs_host_model.sv
// host model that reads the status bank one request at a time
module ifcs_host_model (
  // clock
  input wire logic ref_clk,
  // register read port
  output logic rd_en,
  output logic [5:0] rd_addr,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fill_copy; // saved fill count
  logic [7:0] cond_copy; // saved copy, the last-byte fields self-clear on read
  initial rd_en = 1'b0;
  initial rd_addr = 6'h00;
  // request held over one edge, answer taken 1 ns after that same edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge ref_clk) #1;
    d = rd_data;
    rd_en = 1'b0;
    rd_addr = ~a; // released address never repeats the old one
  endtask
  // both status registers come before any queue data
  task automatic fifo_status;
    rd(6'h1a, fill_copy);
    rd(6'h1b, cond_copy);
  endtask
endmodule

// ===== ifcs_bank_assertions.sv
// port assertions for the status bank
module ifcs_bank_assertions
  import ifcs_pkg::*;
#(parameter int DEPTH = 96) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic set_default,
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  input wire logic main_rd,
  input ifcs_tim_ev_t tim_ev,
  input wire logic [6:0] fifo_count,
  input wire logic fifo_underflow,
  input ifcs_last_t last_info,
  input ifcs_coll_t coll_in,
  input wire logic [1:0] main_summary
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // one host read of an offset
  sequence s_rd(logic [5:0] a);
    rd_en && rd_addr == a;
  endsequence
  a_hit_decode: assert property (rd_hit == (rd_en && rd_addr >= 6'h18 && rd_addr <= 6'h1c))
    else $error("hit decode wrong");
  a_fill_count: assert property ((s_rd(6'h1a) and fifo_count <= DEPTH)
    |=> rd_data == {1'b0, $past(fifo_count)}) else $error("fill count wrong");
  a_top_zero: assert property (s_rd(6'h1a) or s_rd(6'h1b) |=> !rd_data[7])
    else $error("unused top bit set");
  a_tim_sum: assert property (tim_ev != 8'h00 && !set_default
    |-> ##[1:2] main_summary[1]) else $error("timer summary missing");
  a_main_clear: assert property (main_rd && tim_ev == 8'h00 ##1 tim_ev == 8'h00
    ##1 (s_rd(6'h18) and tim_ev == 8'h00) |=> rd_data == 8'h00) else $error("flags kept");
  a_cond_clear: assert property ((s_rd(6'h1b) and !last_info.valid) ##1 !last_info.valid
    ##1 (s_rd(6'h1b) and !last_info.valid) |=> rd_data[4:0] == 5'h00) else $error("byte kept");
  a_empty_clear: assert property (fifo_count == 7'h00 && !last_info.valid
    ##1 (s_rd(6'h1b) and fifo_count == 7'h00) |=> rd_data[4:1] == 4'h0) else $error("not empty");
  a_coll_pos: assert property (coll_in.valid && !coll_in.long_msg
    ##1 !coll_in.valid && !set_default
    ##1 (s_rd(6'h1c) and !coll_in.valid && !set_default) |=> rd_data[7:4] == $past(coll_in.bytes, 3)
    && rd_data[3:1] == $past(coll_in.bits, 3)) else $error("collision position wrong");
  a_unf_flag: assert property (fifo_underflow ##1 !set_default
    ##1 (s_rd(6'h1b) and !set_default) |=> rd_data[6]) else $error("underflow not shown");
endmodule
bind ifcs_bank ifcs_bank_assertions #(.DEPTH(DEPTH)) chk_u (.*);

// ===== test_irq_fifo_collision_status.sv
// self-checking bench for the status bank
module test_irq_fifo_collision_status import ifcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wake_irq_every = 1'b1;
  logic set_default, main_rd, fifo_underflow, fifo_overflow, rd_en, rd_hit;
  logic [5:0] rd_addr;
  logic [7:0] rd_data, d, b;
  logic [1:0] main_summary;
  logic [6:0] fifo_count = 7'h00;
  logic [31:0] rnd = 32'h51; // xorshift state
  logic [35:0] ev = '0; // every pulse input in one word
  int num_errors = 0;
  int num_checks = 0;
  ifcs_tim_ev_t tim_ev;
  ifcs_err_ev_t err_ev;
  ifcs_last_t last_info;
  ifcs_coll_t coll_in;
  assign {set_default, main_rd, tim_ev, err_ev, fifo_underflow, fifo_overflow, last_info,
    coll_in} = ev;
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  ifcs_bank #(.DEPTH(96)) dut_u (.*);
  ifcs_host_model host_u (.ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
  // pulses last one cycle, then the word returns to zero
  task automatic pulse(input logic [35:0] v);
    ev = v;
    @(posedge ref_clk) ev <= '0;
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp) num_errors++;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // incomplete last byte as the second queue register shows it
  function automatic logic [7:0] cond_of(input logic [2:0] bits, input logic np);
    return {4'h1, bits, np};
  endfunction
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (logic [5:0] a = 6'h18; a < 6'h1d; a++) rc(a, 8'h00);
    rc(6'h3f, 8'h00);
    // each event bit alone, then random events cleared by the main read
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      pulse({2'b00, b, b, 18'h00000});
      chk({6'h00, main_summary}, 8'h03);
      rc(6'h18, b);
      rc(6'h19, b);
      pulse('0);
      chk({6'h00, main_summary}, 8'h00);
      rnd = xs(rnd);
      pulse({2'b00, rnd[7:0] | 8'h01, rnd[15:8] | 8'h01, 18'h00000});
      pulse(36'h400000000);
      rc(6'h18, 8'h00);
      rc(6'h19, 8'h00);
    end
    wake_irq_every = 1'b0;
    pulse(36'h000200000);
    rc(6'h19, 8'h00);
    // random fill levels with a full queue first
    for (int n = 0; n < 16; n++) begin
      rnd = xs(rnd);
      fifo_count = (n == 0) ? 7'h60 : 7'h01 + rnd[6:0] % 7'h5f;
      pulse({20'h00000, 2'b11, rnd[10:8], rnd[11], 10'h000});
      host_u.fifo_status();
      chk(host_u.fill_copy, {1'b0, fifo_count});
      chk(host_u.cond_copy, cond_of(rnd[10:8], rnd[11]));
      rc(6'h1b, 8'h00);
    end
    fifo_count = 7'h00;
    pulse({20'h00000, 6'h3f, 10'h000});
    rc(6'h1a, 8'h00);
    rc(6'h1b, 8'h01);
    pulse(36'h000030000);
    rc(6'h1b, 8'h60);
    pulse({26'h0000000, 10'h29b});
    rc(6'h1c, 8'h9b);
    pulse({26'h0000000, 10'h223});
    rc(6'h1c, 8'h22);
    pulse({26'h0000000, 10'h334});
    rc(6'h1c, 8'h22);
    pulse({2'b00, 8'hff, 26'h0000000});
    pulse(36'h800000000);
    for (logic [5:0] a = 6'h18; a < 6'h1d; a++) rc(a, 8'h00);
    report_and_stop;
  end
endmodule
